// *** rtl/acq_pkg.sv ***
// Purpose: Shared constants and carriers for the acquisition chain config block
// Assumes: Classic Wishbone, 32-bit data, one register per aligned word
// Notes:   Printed offsets are word indices, not byte offsets, so index*4 = address
package acq_pkg;

	// Register indices as printed
	localparam logic [7:0] ACQ_IDX_RATE    = 8'h60;
	localparam logic [7:0] ACQ_IDX_REFCTL  = 8'h61;
	localparam logic [7:0] ACQ_IDX_GAIN    = 8'h62;
	localparam logic [7:0] ACQ_IDX_THRESH  = 8'h63;
	localparam logic [7:0] ACQ_IDX_TEMP_HI = 8'h64;
	localparam logic [7:0] ACQ_IDX_TEMP_LO = 8'h65;
	localparam logic [7:0] ACQ_IDX_AGCCTL  = 8'h71;
	localparam logic [7:0] ACQ_IDX_STATUS  = 8'h72;

	// Window bases seen by software
	localparam logic [15:0] ACQ_BASE_BLOCKING    = 16'h0200;
	localparam logic [15:0] ACQ_BASE_NONBLOCKING = 16'h0300;

	// Reset values
	localparam logic [2:0] ACQ_RATE_RESET   = 3'h4;
	localparam logic [1:0] ACQ_REFSEL_RESET = 2'h1;
	localparam logic       ACQ_LDOSEL_RESET = 1'b1;
	localparam logic [2:0] ACQ_REFON_RESET  = 3'h7;
	localparam logic [2:0] AMPLIFIER_GAIN_RESET   = 3'h0;
	localparam logic [7:0] ACQ_THRESH_RESET = 8'h00;

	// Field positions in the reference control register
	localparam int ACQ_REFSEL_LSB = 4;
	localparam int ACQ_LDOSEL_BIT = 3;

	// Timing: modulator sample clock and first stage; auto-gain step-up count
	localparam int ACQ_CLK_HZ      = 100_000_000;
	localparam int ACQ_MOD_HZ      = 512_000;
	localparam int ACQ_MOD_DIV     = ACQ_CLK_HZ / ACQ_MOD_HZ;
	localparam logic [3:0] ACQ_STAGE1_RATIO = 4'h8;
	localparam logic [7:0] AMPLIFIER_GAIN_UP_COUNT = 8'h10;

	typedef struct packed {
		logic [1:0] converter_reference_select;
		logic       regulator_reference_select;
		logic       reference_three_on;
		logic       reference_two_on;
		logic       reference_one_on;
	} acq_ref_t;

	typedef struct packed {
		logic [2:0] decimation_code;
		logic [2:0] amp_gain_code;
		logic       auto_gain_enable;
		logic [3:0] gain_up_thresh;
		logic [3:0] gain_down_thresh;
	} acq_cfg_t;

	// Stage-two ratio (total / 8) for a rate code
	function automatic logic [7:0] acq_stage2_ratio(input logic [2:0] code);
		case (code)
			3'h1:    acq_stage2_ratio = 8'h08;
			3'h2:    acq_stage2_ratio = 8'h10;
			3'h3:    acq_stage2_ratio = 8'h20;
			3'h5:    acq_stage2_ratio = 8'h80;
			default: acq_stage2_ratio = 8'h40;
		endcase
	endfunction : acq_stage2_ratio

endpackage : acq_pkg

// *** rtl/acq_decim_timer.sv ***
// Purpose: Output-rate strobe generator for the two-stage sinc3 decimator
// Assumes: Modulator tick enable from a divider on clk_i
// Notes:   Stage one fixed at eight; stage two counts the remainder
module acq_decim_timer (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic       mod_tick_i,
	input  wire logic [2:0] decimation_code_i,
	// Strobes
	output logic            stage1_done_o,
	output logic            result_strobe_o
);
	import acq_pkg::*;

	logic [3:0] s1_cnt_reg, s1_cnt_next;
	logic [7:0] s2_cnt_reg, s2_cnt_next;
	logic       s1_done_reg, s1_done_next;
	logic       res_reg, res_next;
	logic [7:0] ratio2;

	always_comb begin
		ratio2       = acq_stage2_ratio(decimation_code_i);
		s1_cnt_next  = s1_cnt_reg;
		s2_cnt_next  = s2_cnt_reg;
		s1_done_next = 1'b0;
		res_next     = 1'b0;
		if (mod_tick_i) begin
			if (s1_cnt_reg == ACQ_STAGE1_RATIO - 4'h1) begin
				s1_cnt_next  = 4'h0;
				s1_done_next = 1'b1;
				// Ratio change takes effect at the next boundary
				if (s2_cnt_reg >= ratio2 - 8'h01) begin
					s2_cnt_next = 8'h00;
					res_next    = 1'b1;
				end else begin
					s2_cnt_next = s2_cnt_reg + 8'h01;
				end
			end else begin
				s1_cnt_next = s1_cnt_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_cnt_reg  <= 4'h0;
			s2_cnt_reg  <= 8'h00;
			s1_done_reg <= 1'b0;
			res_reg     <= 1'b0;
		end else begin
			s1_cnt_reg  <= s1_cnt_next;
			s2_cnt_reg  <= s2_cnt_next;
			s1_done_reg <= s1_done_next;
			res_reg     <= res_next;
		end
	end

	assign stage1_done_o   = s1_done_reg;
	assign result_strobe_o = res_reg;

endmodule : acq_decim_timer

// *** rtl/acq_chain_regs.sv ***
// Purpose: Acquisition chain configuration and result registers on Wishbone
// Assumes: Classic Wishbone slave, 32-bit data, byte address = index * 4
// Notes:   Registered ack, one wait state; unmapped addresses ack and read zero
module acq_chain_regs (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Wishbone slave
	input  wire logic                cyc_i,
	input  wire logic                stb_i,
	input  wire logic                we_i,
	input  wire logic [9:0]          adr_i,
	input  wire logic [3:0]          sel_i,
	input  wire logic [31:0]         dat_i,
	output logic [31:0]              dat_o,
	output logic                     ack_o,
	// Analog front-end interface
	input  wire logic [15:0]         temp_result_i,
	input  wire logic                temp_valid_i,
	input  wire logic [3:0]          agc_level_i,
	output acq_pkg::acq_ref_t        ref_ctl_o,
	output acq_pkg::acq_cfg_t        cfg_o,
	output logic [9:0]               amp_gain_o,
	output logic [2:0]               offset_comp_buffer_sel_o,
	output logic                     stage1_done_o,
	output logic                     result_strobe_o
);
	import acq_pkg::*;

	function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
		hit = (adr[9:2] == idx);
	endfunction : hit

	// Register state
	logic [2:0]  rate_reg, rate_next;
	acq_ref_t    ref_reg, ref_next;
	logic [2:0]  gain_reg, gain_next;
	logic [7:0]  thr_reg, thr_next;
	logic        gain_auto_reg, gain_auto_next;
	logic [15:0] temp_reg, temp_next;
	logic        ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;
	logic [7:0]  up_cnt_reg, up_cnt_next;
	logic        bad_ref_reg, bad_ref_next;
	// Divide-by-195 needs eight bits; seven would wrap early
	logic [7:0]  mod_div_reg, mod_div_next;
	logic        mod_tick_reg, mod_tick_next;

	logic        wr_en;
	logic        rd_en;
	logic        lane0;

	// Synchroniser for analog temperature valid
	logic        tv_s1_reg, tv_s2_reg, tv_s3_reg;
	logic        tv_settled;

	assign wr_en = cyc_i && stb_i && we_i && !ack_reg;
	assign rd_en = cyc_i && stb_i && !we_i && !ack_reg;
	assign lane0 = sel_i[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tv_s1_reg <= 1'b0;
			tv_s2_reg <= 1'b0;
			tv_s3_reg <= 1'b0;
		end else begin
			tv_s1_reg <= temp_valid_i;
			tv_s2_reg <= tv_s1_reg;
			tv_s3_reg <= tv_s2_reg;
		end
	end
	// Counted once the later two stages agree on the new level
	assign tv_settled = tv_s2_reg && tv_s3_reg;

	// Modulator tick divider
	always_comb begin
		mod_div_next  = mod_div_reg + 8'h01;
		mod_tick_next = 1'b0;
		if (mod_div_reg == 8'(ACQ_MOD_DIV - 1)) begin
			mod_div_next  = 8'h00;
			mod_tick_next = 1'b1;
		end
	end

	// Bus and register next-state
	always_comb begin
		rate_next    = rate_reg;
		ref_next     = ref_reg;
		gain_next    = gain_reg;
		thr_next     = thr_reg;
		gain_auto_next = gain_auto_reg;
		temp_next    = temp_reg;
		up_cnt_next  = up_cnt_reg;
		bad_ref_next = bad_ref_reg;
		ack_next     = cyc_i && stb_i && !ack_reg;
		rdat_next    = rdat_reg;

		// Result latched on the settled level, data stable by then
		if (tv_settled) begin
			temp_next = temp_result_i;
		end

		// Automatic gain: compare each result against thresholds
		if (gain_auto_reg && result_strobe_o) begin
			if (agc_level_i >= thr_reg[7:4] && gain_reg != 3'h0) begin
				gain_next   = gain_reg - 3'h1;
				up_cnt_next = 8'h00;
			end else if (agc_level_i < thr_reg[3:0] && gain_reg != 3'h7) begin
				// Hysteresis so gain does not hunt on noise
				if (up_cnt_reg == AMPLIFIER_GAIN_UP_COUNT - 8'h01) begin
					gain_next   = gain_reg + 3'h1;
					up_cnt_next = 8'h00;
				end else begin
					up_cnt_next = up_cnt_reg + 8'h01;
				end
			end else begin
				up_cnt_next = 8'h00;
			end
		end

		if (wr_en && lane0) begin
			if (hit(adr_i, ACQ_IDX_RATE)) begin
				rate_next = dat_i[2:0];
			end
			if (hit(adr_i, ACQ_IDX_REFCTL)) begin
				// Code 00 would reset the analog supply; refused and flagged
				if (dat_i[ACQ_REFSEL_LSB +: 2] != 2'h0) begin
					ref_next.converter_reference_select = dat_i[ACQ_REFSEL_LSB +: 2];
				end else begin
					bad_ref_next = 1'b1;
				end
				ref_next.regulator_reference_select = dat_i[ACQ_LDOSEL_BIT];
			end
			if (hit(adr_i, ACQ_IDX_GAIN) && !gain_auto_reg) begin
				gain_next = dat_i[2:0];
			end
			if (hit(adr_i, ACQ_IDX_THRESH)) begin
				thr_next = dat_i[7:0];
			end
			if (hit(adr_i, ACQ_IDX_AGCCTL)) begin
				gain_auto_next = dat_i[0];
			end
			if (hit(adr_i, ACQ_IDX_STATUS) && dat_i[0]) begin
				bad_ref_next = 1'b0;
			end
		end

		if (rd_en) begin
			case (adr_i[9:2])
				ACQ_IDX_RATE:    rdat_next = {29'h0, rate_reg};
				ACQ_IDX_REFCTL:  rdat_next = {26'h0, ref_reg};
				ACQ_IDX_GAIN:    rdat_next = {29'h0, gain_reg};
				ACQ_IDX_THRESH:  rdat_next = {24'h0, thr_reg};
				ACQ_IDX_TEMP_HI: rdat_next = {24'h0, temp_reg[15:8]};
				ACQ_IDX_TEMP_LO: rdat_next = {24'h0, temp_reg[7:0]};
				ACQ_IDX_AGCCTL:  rdat_next = {31'h0, gain_auto_reg};
				ACQ_IDX_STATUS:  rdat_next = {31'h0, bad_ref_reg};
				default:         rdat_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rate_reg     <= ACQ_RATE_RESET;
			ref_reg      <= {ACQ_REFSEL_RESET, ACQ_LDOSEL_RESET, ACQ_REFON_RESET};
			gain_reg     <= AMPLIFIER_GAIN_RESET;
			thr_reg      <= ACQ_THRESH_RESET;
			gain_auto_reg <= 1'b0;
			temp_reg     <= 16'h0;
			ack_reg      <= 1'b0;
			rdat_reg     <= 32'h0;
			up_cnt_reg   <= 8'h00;
			bad_ref_reg  <= 1'b0;
			mod_div_reg  <= 8'h00;
			mod_tick_reg <= 1'b0;
		end else begin
			rate_reg     <= rate_next;
			ref_reg      <= ref_next;
			gain_reg     <= gain_next;
			thr_reg      <= thr_next;
			gain_auto_reg <= gain_auto_next;
			temp_reg     <= temp_next;
			ack_reg      <= ack_next;
			rdat_reg     <= rdat_next;
			up_cnt_reg   <= up_cnt_next;
			bad_ref_reg  <= bad_ref_next;
			mod_div_reg  <= mod_div_next;
			mod_tick_reg <= mod_tick_next;
		end
	end

	acq_decim_timer u_timer (
		.clk_i             (clk_i),
		.rst_i             (rst_i),
		.mod_tick_i        (mod_tick_reg),
		.decimation_code_i (rate_reg),
		.stage1_done_o     (stage1_done_o),
		.result_strobe_o   (result_strobe_o)
	);

	assign ack_o                    = ack_reg;
	assign dat_o                    = rdat_reg;
	assign ref_ctl_o                = ref_reg;
	assign cfg_o                    = {rate_reg, gain_reg, gain_auto_reg, thr_reg};
	assign amp_gain_o               = 10'h004 << gain_reg;
	assign offset_comp_buffer_sel_o = gain_reg;

endmodule : acq_chain_regs

// *** bench/acq_chain_regs_chk.sv ***
// Purpose: Port-level checks for the acquisition register block
// Assumes: Registered ack one cycle after a taken request
// Notes:   Sees only the top module's ports
module acq_chain_regs_chk
	import acq_pkg::*;
(
	// Clock, reset and bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [9:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic        ack_o,
	// Front-end side
	input acq_ref_t         ref_ctl_o,
	input acq_cfg_t         cfg_o,
	input wire logic [9:0]  amp_gain_o,
	input wire logic [2:0]  offset_comp_buffer_sel_o,
	input wire logic        stage1_done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence taken_s;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence wr_s(logic [7:0] idx);
		taken_s ##0 (we_i && sel_i[0] && adr_i[9:2] == idx);
	endsequence
	ack_latency_a: assert property (taken_s |=> ack_o) else $error("ack late");
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
	rate_write_a: assert property (wr_s(8'h60) |=> cfg_o.decimation_code == $past(dat_i[2:0]))
		else $error("rate code not written");
	manual_gain_a: assert property (wr_s(8'h62) ##0 !cfg_o.auto_gain_enable
		|=> cfg_o.amp_gain_code == $past(dat_i[2:0])) else $error("manual gain lost");
	gain_value_a: assert property (amp_gain_o == (10'h004 << cfg_o.amp_gain_code))
		else $error("gain value wrong");
	buffer_sel_a: assert property (offset_comp_buffer_sel_o == cfg_o.amp_gain_code)
		else $error("buffer entry wrong");
	ref_legal_a: assert property (ref_ctl_o.converter_reference_select != 2'h0)
		else $error("reference select zero");
	refs_on_a: assert property (ref_ctl_o[2:0] == 3'h7) else $error("reference off");
	stage1_pulse_a: assert property (stage1_done_o |=> !stage1_done_o)
		else $error("stage one strobe long");
endmodule : acq_chain_regs_chk

bind acq_chain_regs acq_chain_regs_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
	.ref_ctl_o(ref_ctl_o), .cfg_o(cfg_o), .amp_gain_o(amp_gain_o),
	.offset_comp_buffer_sel_o(offset_comp_buffer_sel_o), .stage1_done_o(stage1_done_o));

// *** bench/acq_chain_regs_bench.sv ***
// Purpose: Register-level test of the acquisition chain block
// Assumes: Byte address is index times four
// Notes:   Rate code 1 keeps strobe periods short
module acq_chain_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import acq_pkg::*;
	logic        clk_i = 0;
	logic        rst_i = 1;
	logic        cyc = 0, stb = 0, we = 0;
	logic [9:0]  adr = 0;
	logic [3:0]  sel = 0;
	logic [31:0] wd = 0, dat_o, q;
	logic        ack_o, s1, rs;
	logic [15:0] temp = 0;
	logic        tv = 0;
	logic [3:0]  lvl = 0;
	acq_ref_t    ref_ctl;
	acq_cfg_t    cfg;
	logic [9:0]  amp;
	logic [2:0]  bsel;
	int          fail_count = 0, n_checks = 0, i;
	acq_chain_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(dat_o), .ack_o(ack_o),
		.temp_result_i(temp), .temp_valid_i(tv), .agc_level_i(lvl), .ref_ctl_o(ref_ctl),
		.cfg_o(cfg), .amp_gain_o(amp), .offset_comp_buffer_sel_o(bsel),
		.stage1_done_o(s1), .result_strobe_o(rs));
	always #5 clk_i = ~clk_i;
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_i);
		{cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, s};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o;
		{cyc, stb} <= 2'b00;
		if (n >= 50) begin
			chk("ack wait", 1, 0);
			finish_test();
		end
	endtask : wb
	task automatic rd(input logic [9:0] a, input logic [31:0] e, input string nm);
		wb(0, a, 0, 4'hf);
		chk(nm, e, q);
	endtask : rd
	task automatic per(input bit r, input int e, input string nm);
		int k;
		for (k = 0; (r ? rs : s1) !== 1'b1 && k < 30000; k++) @(posedge clk_i);
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while ((r ? rs : s1) !== 1'b1 && k < 30000);
		chk(nm, e, k);
	endtask : per
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		rd(10'h180, 32'h04, "rate reset");
		chk("ref port", 32'h1f, ref_ctl);
		rd(10'h184, 32'h1f, "ref reset");
		rd(10'h188, 32'h00, "gain reset");
		for (i = 0; i < 8; i++) begin
			wb(1, 10'h180, 32'hf8 | i, 4'h1);
			rd(10'h180, i, "rate code");
		end
		wb(1, 10'h180, 32'h1, 4'h1);
		per(0, ACQ_MOD_DIV * 8, "stage one period");
		per(1, ACQ_MOD_DIV * 64, "result period");
		wb(1, 10'h184, 32'h24, 4'h1);
		wb(1, 10'h184, 32'h00, 4'h1);
		rd(10'h184, 32'h27, "ref select");
		rd(10'h1c8, 32'h01, "bad ref flag");
		wb(1, 10'h184, 32'h3f, 4'h1);
		rd(10'h184, 32'h3f, "ref three");
		for (i = 0; i < 8; i++) begin
			wb(1, 10'h188, 32'hf8 | i, 4'h1);
			rd(10'h188, i, "gain code");
			chk("gain value", 32'h4 << i, amp);
			chk("buffer entry", i, bsel);
		end
		wb(1, 10'h188, 32'h3, 4'h0);
		rd(10'h188, 32'h7, "gain no lane");
		wb(1, 10'h18c, 32'hf0, 4'h1);
		rd(10'h18c, 32'hf0, "thresholds");
		chk("up nibble", 4'hf, cfg.gain_up_thresh);
		lvl <= 4'h5;
		wb(1, 10'h1c4, 32'h1, 4'h1);
		wb(1, 10'h188, 32'h2, 4'h1);
		rd(10'h188, 32'h7, "auto gain hold");
		lvl <= 4'hf;
		per(1, ACQ_MOD_DIV * 64, "auto period");
		lvl <= 4'h5;
		repeat (4) @(posedge clk_i);
		rd(10'h188, 32'h5, "auto step");
		temp <= 16'hbeef;
		tv <= 1;
		repeat (8) @(posedge clk_i);
		wb(1, 10'h190, 32'h0, 4'hf);
		rd(10'h190, 32'hbe, "temp high");
		rd(10'h194, 32'hef, "temp low");
		rd(10'h3fc, 32'h0, "unmapped");
		finish_test();
	end
endmodule : acq_chain_regs_bench
